// File: logic/cbc_pkg.sv
// Package: register map, field layout, reset values and timing counts
package cbc_pkg;
  // ----------------------------------------
  // Register offsets (printed offsets, not multiples of four: index)
  // ----------------------------------------
  localparam logic [15:0] UPPER_EN_IDX   = 16'h1003;
  localparam logic [15:0] HOLDOFF_IDX    = 16'h1004;
  localparam logic [15:0] DISCH_KEY_IDX  = 16'h1005;
  localparam logic [15:0] LOWER_EN_IDX   = 16'h1002;
  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int          HI_BIT         = 1;
  localparam int          LO_BIT         = 0;
  localparam int          UPPER_CH       = 2;
  localparam int          LOWER_CH       = 16;
  localparam int          ALL_CH         = 18;
  localparam logic [15:0] UPPER_EN_RST   = 16'h0000;
  localparam logic [15:0] LOWER_EN_RST   = 16'h0000;
  localparam logic [15:0] HOLDOFF_RST    = 16'h0000;
  localparam logic [15:0] KEY_ENABLE     = 16'hDEAD;
  localparam logic [15:0] KEY_DISABLE    = 16'h2152;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint      CLK_HZ         = 100000000;
  localparam longint      TICK_S         = 10;
  localparam longint      TICK_CYC       = CLK_HZ * TICK_S;
endpackage : cbc_pkg

// File: logic/cbc_tick.sv
// Prescaler giving a one-cycle pulse once per holdoff period
module cbc_tick #(
  parameter logic [31:0] PERIOD = 32'h3B9A_CA00
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic run_i,
  output logic      tick_o
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        nxt_tick;

  // Count restarts whenever counting is not wanted, so each count is a full period
  assign nxt_tick = run_i && (cnt_ff == PERIOD - 32'h0000_0001);
  assign nxt_cnt  = (!run_i || nxt_tick) ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;

  // Counter and pulse register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_ff  <= 32'h0000_0000;
      tick_o  <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_o  <= nxt_tick;
    end
  end
endmodule // cbc_tick

// File: logic/cbc_regs.sv
// Cell balancing control registers: channel enables, holdoff counter, discharge key
//
// The implementer's own choice: strobed register access.
module cbc_regs #(
  parameter logic [31:0] TICK_CYCLES = 32'(cbc_pkg::TICK_CYC)
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        global_balance_on_i,
  input  wire logic [17:0] over_current_i,
  input  wire logic [17:0] under_voltage_i,
  input  wire logic [17:0] chan_timeout_i,
  output logic      [17:0] chan_balance_o,
  output logic      [17:0] chan_timer_run_o,
  output logic             global_timeout_run_o,
  output logic             holdoff_active_o,
  output logic             discharge_on_o
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic        sel_upper;
  logic        sel_lower;
  logic        sel_hold;
  logic        sel_key;
  logic        wr_upper;
  logic        wr_lower;
  logic        wr_hold;
  logic        wr_key;

  assign sel_upper = (addr_i == cbc_pkg::UPPER_EN_IDX);
  assign sel_lower = (addr_i == cbc_pkg::LOWER_EN_IDX);
  assign sel_hold  = (addr_i == cbc_pkg::HOLDOFF_IDX);
  assign sel_key   = (addr_i == cbc_pkg::DISCH_KEY_IDX);
  assign wr_upper  = wr_i && sel_upper;
  assign wr_lower  = wr_i && sel_lower;
  assign wr_hold   = wr_i && sel_hold;
  assign wr_key    = wr_i && sel_key;

  // ----------------------------------------
  // Channel enables
  // ----------------------------------------
  logic [17:0] chan_en_ff;
  logic [17:0] nxt_chan_en;
  logic [17:0] chan_wr;
  logic [17:0] chan_wdata;
  logic [17:0] chan_kill;

  // Lower sixteen from the lower register, upper two from bits 1:0 only
  assign chan_wr    = {{cbc_pkg::UPPER_CH{wr_upper}}, {cbc_pkg::LOWER_CH{wr_lower}}};
  assign chan_wdata = {wdata_i[cbc_pkg::HI_BIT:cbc_pkg::LO_BIT], wdata_i};
  assign chan_kill  = over_current_i | under_voltage_i | chan_timeout_i;

  // Device clear beats a software set in the same cycle: a fault must never be missed
  genvar g;
  generate
    for (g = 0; g < cbc_pkg::ALL_CH; g++) begin : g_chan
      assign nxt_chan_en[g] = chan_kill[g] ? 1'b0 :
                              (chan_wr[g] ? chan_wdata[g] : chan_en_ff[g]);
    end
  endgenerate

  // ----------------------------------------
  // Holdoff counter
  // ----------------------------------------
  logic [15:0] holdoff_count_ff;
  logic [15:0] nxt_holdoff;
  logic        tick;
  logic        hold_run;

  assign hold_run = global_balance_on_i && (holdoff_count_ff != 16'h0000);

  cbc_tick #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .run_i   (hold_run),
    .tick_o  (tick)
  );

  // Write loads at once; decrement only on tick, and only above zero
  assign nxt_holdoff = wr_hold ? wdata_i :
                       ((tick && hold_run) ? holdoff_count_ff - 16'h0001
                                           : holdoff_count_ff);

  // ----------------------------------------
  // Discharge key
  // ----------------------------------------
  logic [15:0] key_ff;
  logic        disch_ff;
  logic        nxt_disch;

  assign nxt_disch = (wr_key && wdata_i == cbc_pkg::KEY_ENABLE)  ? 1'b1 :
                     (wr_key && wdata_i == cbc_pkg::KEY_DISABLE) ? 1'b0 :
                     disch_ff;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [15:0] nxt_rdata;

  assign nxt_rdata = !rd_i     ? 16'h0000 :
                     sel_upper ? {14'h0000, chan_en_ff[17:16]} :
                     sel_lower ? chan_en_ff[15:0] :
                     sel_hold  ? holdoff_count_ff :
                     sel_key   ? key_ff :
                     16'h0000;

  // ----------------------------------------
  // Outputs, derived next values
  // ----------------------------------------
  logic        nxt_hold_act;
  logic [17:0] nxt_bal;
  logic [17:0] nxt_trun;

  // Holdoff active while counter nonzero and balancing requested
  assign nxt_hold_act = global_balance_on_i && (nxt_holdoff != 16'h0000);
  assign nxt_bal      = (global_balance_on_i && !nxt_hold_act) ? nxt_chan_en
                                                              : 18'h00000;
  assign nxt_trun     = nxt_bal;

  // Register state
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      chan_en_ff       <= {cbc_pkg::UPPER_EN_RST[1:0], cbc_pkg::LOWER_EN_RST};
      holdoff_count_ff <= cbc_pkg::HOLDOFF_RST;
      key_ff           <= cbc_pkg::KEY_DISABLE;
      disch_ff         <= 1'b0;
    end else begin
      chan_en_ff       <= nxt_chan_en;
      holdoff_count_ff <= nxt_holdoff;
      key_ff           <= wr_key ? wdata_i : key_ff;
      disch_ff         <= nxt_disch;
    end
  end

  // Output flops
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_o              <= 16'h0000;
      chan_balance_o       <= 18'h00000;
      chan_timer_run_o     <= 18'h00000;
      global_timeout_run_o <= 1'b0;
      holdoff_active_o     <= 1'b0;
      discharge_on_o       <= 1'b0;
    end else begin
      rdata_o              <= nxt_rdata;
      chan_balance_o       <= nxt_bal;
      chan_timer_run_o     <= nxt_trun;
      global_timeout_run_o <= global_balance_on_i;
      holdoff_active_o     <= nxt_hold_act;
      discharge_on_o       <= nxt_disch;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_rsvd_zero;
    @(posedge mclk_i) disable iff (reset_i)
      $past(rd_i) && $past(sel_upper) |-> rdata_o[15:2] == 14'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_kill;
    @(posedge mclk_i) disable iff (reset_i)
      chan_kill[17] |=> !chan_en_ff[17];
  endproperty
  a_kill: assert property (p_kill) else $error("channel enable not cleared");

  property p_timer_stop;
    @(posedge mclk_i) disable iff (reset_i)
      !chan_en_ff[16] |-> !chan_timer_run_o[16];
  endproperty
  a_timer_stop: assert property (p_timer_stop) else $error("timer runs while disabled");

  property p_hold_block;
    @(posedge mclk_i) disable iff (reset_i)
      holdoff_active_o |-> chan_balance_o == 18'h00000 && chan_timer_run_o == 18'h00000;
  endproperty
  a_hold_block: assert property (p_hold_block) else $error("balancing during holdoff");

  property p_no_wrap;
    @(posedge mclk_i) disable iff (reset_i)
      holdoff_count_ff == 16'h0000 && !wr_hold |=> holdoff_count_ff == 16'h0000;
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("holdoff wrapped");

  property p_hold_freeze;
    @(posedge mclk_i) disable iff (reset_i)
      !global_balance_on_i && !wr_hold |=> $stable(holdoff_count_ff);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("holdoff moved while off");

  property p_hold_read;
    @(posedge mclk_i) disable iff (reset_i)
      rd_i && sel_hold |=> rdata_o == $past(holdoff_count_ff);
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("holdoff read mismatch");

  property p_key_on;
    @(posedge mclk_i) disable iff (reset_i)
      wr_key && wdata_i == cbc_pkg::KEY_ENABLE |=> discharge_on_o;
  endproperty
  a_key_on: assert property (p_key_on) else $error("discharge not started");

  property p_key_other;
    @(posedge mclk_i) disable iff (reset_i)
      wr_key && wdata_i != cbc_pkg::KEY_ENABLE && wdata_i != cbc_pkg::KEY_DISABLE
      |=> discharge_on_o == $past(disch_ff);
  endproperty
  a_key_other: assert property (p_key_other) else $error("other key changed state");

  property p_glob;
    @(posedge mclk_i) disable iff (reset_i)
      global_balance_on_i |=> global_timeout_run_o;
  endproperty
  a_glob: assert property (p_glob) else $error("global timer held");

  property p_kill_lo;
    @(posedge mclk_i) disable iff (reset_i)
      chan_kill[16] |=> !chan_en_ff[16];
  endproperty
  a_kill_lo: assert property (p_kill_lo) else $error("channel 16 enable not cleared");

  property p_timer_stop_hi;
    @(posedge mclk_i) disable iff (reset_i)
      !chan_en_ff[17] |-> !chan_timer_run_o[17];
  endproperty
  a_timer_stop_hi: assert property (p_timer_stop_hi) else $error("timer not stopped");

  property p_upper_wr;
    @(posedge mclk_i) disable iff (reset_i)
      wr_upper && !chan_kill[17] |=> chan_en_ff[17] == $past(wdata_i[cbc_pkg::HI_BIT]);
  endproperty
  a_upper_wr: assert property (p_upper_wr) else $error("upper enable write lost");

  property p_lower_wr;
    @(posedge mclk_i) disable iff (reset_i)
      wr_lower && !chan_kill[0] |=> chan_en_ff[0] == $past(wdata_i[0]);
  endproperty
  a_lower_wr: assert property (p_lower_wr) else $error("lower enable write lost");

  property p_rsvd_wr;
    @(posedge mclk_i) disable iff (reset_i)
      wr_upper && chan_kill[15:0] == 16'h0000 |=> $stable(chan_en_ff[15:0]);
  endproperty
  a_rsvd_wr: assert property (p_rsvd_wr) else $error("upper write spilled");

  property p_hold_dec;
    @(posedge mclk_i) disable iff (reset_i)
      tick && hold_run && !wr_hold |=> holdoff_count_ff == $past(holdoff_count_ff) - 16'h0001;
  endproperty
  a_hold_dec: assert property (p_hold_dec) else $error("holdoff did not step");

  property p_hold_load;
    @(posedge mclk_i) disable iff (reset_i)
      wr_hold |=> holdoff_count_ff == $past(wdata_i);
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("holdoff write not loaded");

  property p_hold_gate;
    @(posedge mclk_i) disable iff (reset_i)
      !hold_run |=> !tick;
  endproperty
  a_hold_gate: assert property (p_hold_gate) else $error("tick while holdoff idle");

  property p_hold_release;
    @(posedge mclk_i) disable iff (reset_i)
      global_balance_on_i && holdoff_count_ff == 16'h0000 && !wr_hold |=> !holdoff_active_o;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("zero holdoff blocks");

  property p_glob_off;
    @(posedge mclk_i) disable iff (reset_i)
      !global_balance_on_i |=> chan_balance_o == 18'h00000;
  endproperty
  a_glob_off: assert property (p_glob_off) else $error("balancing while global off");

  property p_key_off;
    @(posedge mclk_i) disable iff (reset_i)
      wr_key && wdata_i == cbc_pkg::KEY_DISABLE |=> !discharge_on_o;
  endproperty
  a_key_off: assert property (p_key_off) else $error("discharge not stopped");

  property p_key_keep;
    @(posedge mclk_i) disable iff (reset_i)
      !wr_key |=> discharge_on_o == $past(disch_ff);
  endproperty
  a_key_keep: assert property (p_key_keep) else $error("discharge changed without key");
endmodule // cbc_regs

// File: sim/cbc_regs_tb_top.sv
// Testbench: register access, device clears, holdoff countdown and discharge key
module cbc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 4;  // Short prescale keeps the countdown within a few cycles
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        glob_on = 1'b0;
  logic [17:0] oc = '0;
  logic [17:0] uv = '0;
  logic [17:0] tmo = '0;
  logic [15:0] rdata_o;
  logic [17:0] chan_balance_o;
  logic [17:0] chan_timer_run_o;
  logic        global_timeout_run_o;
  logic        holdoff_active_o;
  logic        discharge_on_o;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [15:0] v;
  cbc_regs #(.TICK_CYCLES(32'(TICKS))) u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .global_balance_on_i(glob_on), .over_current_i(oc),
    .under_voltage_i(uv), .chan_timeout_i(tmo), .chan_balance_o(chan_balance_o),
    .chan_timer_run_o(chan_timer_run_o), .global_timeout_run_o(global_timeout_run_o),
    .holdoff_active_o(holdoff_active_o), .discharge_on_o(discharge_on_o));
  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // A hung wait loop would otherwise run forever; 3000 cycles is well past the plan
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] e);
    rd(a, v);
    check(what, 32'(v), 32'(e));
  endtask
  // Let the write edge land, then 1 ns more so registered outputs settle
  task automatic settle();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd_chk("upper rst", cbc_pkg::UPPER_EN_IDX, 16'h0000);
    rd_chk("holdoff rst", cbc_pkg::HOLDOFF_IDX, 16'h0000);
    rd_chk("lower rst", cbc_pkg::LOWER_EN_IDX, 16'h0000);
    rd_chk("key rst", cbc_pkg::DISCH_KEY_IDX, 16'h2152);
    check("disch rst", 32'(discharge_on_o), 32'h0);
    // Read data stand one cycle only: the nonzero key word must be gone a cycle later
    settle();
    check("rdata idle", 32'(rdata_o), 32'h0);
    // Reserved upper bits ignored; an unmapped place reads zero
    wr(cbc_pkg::UPPER_EN_IDX, 16'hFFFF);
    wr(16'h1006, 16'hFFFF);
    rd_chk("upper rsv", cbc_pkg::UPPER_EN_IDX, 16'h0003);
    rd_chk("unmapped", 16'h1006, 16'h0000);
    wr(cbc_pkg::LOWER_EN_IDX, 16'hA5A5);
    rd_chk("lower rw", cbc_pkg::LOWER_EN_IDX, 16'hA5A5);
    check("bal off", 32'(chan_balance_o), 32'h0);
    check("glob off", 32'(global_timeout_run_o), 32'h0);
    @(posedge mclk_i);
    glob_on <= 1'b1;
    settle();
    settle();
    check("bal on", 32'(chan_balance_o), 32'h3A5A5);
    check("tmr on", 32'(chan_timer_run_o), 32'h3A5A5);
    check("glob tmr", 32'(global_timeout_run_o), 32'h1);
    // Each fault clears its own enable and stops its timer
    for (int k = 0; k < 3; k++) begin
      wr(cbc_pkg::UPPER_EN_IDX, 16'h0003);
      @(posedge mclk_i);
      if (k == 0) oc[17] <= 1'b1;
      if (k == 1) uv[17] <= 1'b1;
      if (k == 2) tmo[17] <= 1'b1;
      @(posedge mclk_i);
      oc <= '0;
      uv <= '0;
      tmo <= '0;
      rd_chk("fault clr", cbc_pkg::UPPER_EN_IDX, 16'h0001);
      check("tmr stop", 32'(chan_timer_run_o[17:16]), 32'h1);
    end
    wr(cbc_pkg::UPPER_EN_IDX, 16'h0003);
    // Holdoff: load with global off, then count down while global is on
    glob_on <= 1'b0;
    wr(cbc_pkg::HOLDOFF_IDX, 16'h0003);
    repeat (20) @(posedge mclk_i);
    rd_chk("hold frozen", cbc_pkg::HOLDOFF_IDX, 16'h0003);
    check("glob stop", 32'(global_timeout_run_o), 32'h0);
    @(posedge mclk_i);
    glob_on <= 1'b1;
    settle();
    settle();
    check("hold act", 32'(holdoff_active_o), 32'h1);
    check("hold blk", 32'(chan_balance_o), 32'h0);
    check("hold tmr", 32'(chan_timer_run_o), 32'h0);
    check("glob run", 32'(global_timeout_run_o), 32'h1);
    // One prescale period first, so the read must show a count below the written one
    repeat (TICKS) @(posedge mclk_i);
    rd(cbc_pkg::HOLDOFF_IDX, v);
    check("hold live", 32'(v == 16'h0002 || v == 16'h0001), 32'h1);
    n = 0;
    while (holdoff_active_o !== 1'b0 && n < 40) begin
      settle();
      n++;
    end
    check("hold len", 32'(n >= 4 && n <= 12), 32'h1);
    repeat (12) @(posedge mclk_i);
    rd_chk("hold sat", cbc_pkg::HOLDOFF_IDX, 16'h0000);
    check("bal resume", 32'(chan_balance_o), 32'h3A5A5);
    // A write after the count has reached zero reloads at once; max value is accepted
    wr(cbc_pkg::HOLDOFF_IDX, 16'hFFFF);
    rd(cbc_pkg::HOLDOFF_IDX, v);
    check("hold load", 32'(v >= 16'hFFFE), 32'h1);
    wr(cbc_pkg::HOLDOFF_IDX, 16'h0000);
    // Discharge key: only the two keys change state
    wr(cbc_pkg::DISCH_KEY_IDX, 16'h0001);
    settle();
    check("key other", 32'(discharge_on_o), 32'h0);
    rd_chk("key rb", cbc_pkg::DISCH_KEY_IDX, 16'h0001);
    wr(cbc_pkg::DISCH_KEY_IDX, 16'hDEAD);
    settle();
    check("key en", 32'(discharge_on_o), 32'h1);
    wr(cbc_pkg::DISCH_KEY_IDX, 16'h0001);
    wr(cbc_pkg::DISCH_KEY_IDX, 16'h1234);
    settle();
    check("key hold", 32'(discharge_on_o), 32'h1);
    wr(cbc_pkg::DISCH_KEY_IDX, 16'h2152);
    settle();
    check("key dis", 32'(discharge_on_o), 32'h0);
    final_report();
  end
endmodule  // cbc_regs_tb_top
